/* design/mem_ctrl_end.sv */
// Controller end: issues commands and keeps every spacing on the link except the locked-loop wait before termination
// Operation
// - stay in power-down at least minimum width
// - frozen exit to locked command waits longer
// - exit to other commands waits shorter
// - device takes commands two clocks after entry
// - activate/precharge/refresh gap before power-down
// - read gap read latency plus five
// - write gap latency, recovery, burst extra
// - auto-precharge write gap adds one more
// - mode set waits update delay first
// - device switches termination asynchronously when frozen
// - hold termination four or six clocks
// - calibration periods block all commands
// - levelling strobe waits 25 then 40
// - device returns sampled clock level promptly
// - reads and termination need locked loop; only reads wait for it, termination does not
// - device write starts after latency plus burst
// - device finishes pending work in power-down
// - refresh entry may need extra exit time
// - user spaces short calibrations for drift
// - link clock may be stretched freely
// - pattern readout then mode set gap
`timescale 1ns/10ps
`default_nettype none
module mem_ctrl_end #(
   parameter int READ_LATENCY  = 5,
   parameter int WRITE_LATENCY = 5,
   parameter int WRITE_RECOVERY = 12,
   parameter int LINK_TCK_PS   = 160000
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // User request
   input  wire logic       req_valid,
   output logic            req_ready,
   input  wire logic [3:0] req_cmd,
   input  wire logic       req_chop,
   input  wire logic       req_power_down,
   input  wire logic       req_frozen,
   input  wire logic       req_term,
   input  wire logic       req_strobe,
   output logic            level_sample,
   // Link
   mem_link_if.ctrl        link
);
   typedef enum {ST_RUN, ST_PD, ST_LEVEL} state_type;
   localparam int EXIT_GAP = mem_timing_pkg::ns_or_nck(
      mem_timing_pkg::EXIT_NS, mem_timing_pkg::EXIT_NCK, LINK_TCK_PS);
   localparam int FROZEN_GAP = mem_timing_pkg::ns_or_nck(
      mem_timing_pkg::FROZEN_EXIT_NS, mem_timing_pkg::FROZEN_EXIT_NCK,
      LINK_TCK_PS);
   localparam int WR_REC_NCK = WRITE_RECOVERY;

   state_type  state;
   state_type  next_state;
   logic [4:0] div;
   logic       lclk;
   logic [9:0] cmd_wait;     // Link clocks before any next command
   logic [9:0] locked_wait;  // Extra wait for loop-locked commands
   logic [9:0] pd_wait;      // Link clocks before power-down entry
   logic [9:0] pd_count;
   logic [9:0] term_count;
   logic [9:0] level_count;
   logic [2:0] level_sync;
   logic [3:0] cmd_out;
   logic       chop_out;

   wire rise = (div == 5'(mem_timing_pkg::LINK_HALF_DIV - 1)) && !lclk;
   wire needs_lock = (req_cmd == mem_timing_pkg::CMD_RD)
                   || (req_cmd == mem_timing_pkg::CMD_RDA);
   wire term_busy = (term_count != 10'h000);
   wire run_ok = (state == ST_RUN) && (cmd_wait == 10'h000)
               && !(needs_lock && locked_wait != 10'h000);
   wire enter_pd = run_ok && req_power_down && (pd_wait == 10'h000)
                 && !term_busy;
   wire exit_pd = (state == ST_PD) && !req_power_down
                && (pd_count >= 10'(mem_timing_pkg::PD_MIN_LINK));
   wire fire = rise && run_ok && req_valid && !req_power_down;
   wire drop_term = term_busy && !req_term;
   wire wr_long = fire && !req_chop && (req_cmd == mem_timing_pkg::CMD_WR
                || req_cmd == mem_timing_pkg::CMD_WRA);

   assign req_ready = fire;

   function automatic logic [9:0] max10(input logic [9:0] a,
                                       input logic [9:0] b);
      return (a > b) ? a : b;
   endfunction : max10

   // Entry gap owed after each command
   function automatic logic [9:0] pd_gap(input logic [3:0] c,
                                         input logic ch);
      int ext;
      int g;
      ext = ch ? mem_timing_pkg::CHOP4_EXTRA : mem_timing_pkg::BURST8_EXTRA;
      case (c)
         mem_timing_pkg::CMD_ACT, mem_timing_pkg::CMD_PRE,
         mem_timing_pkg::CMD_REF:
            g = mem_timing_pkg::ACT_PDEN_NCK;
         mem_timing_pkg::CMD_RD, mem_timing_pkg::CMD_RDA:
            g = READ_LATENCY + mem_timing_pkg::RD_PDEN_EXTRA;
         mem_timing_pkg::CMD_WR:
            g = WRITE_LATENCY + ext + WR_REC_NCK;
         mem_timing_pkg::CMD_WRA:
            g = WRITE_LATENCY + ext + WRITE_RECOVERY + 1;
         mem_timing_pkg::CMD_MRS:
            g = mem_timing_pkg::MOD_NCK;
         default:
            g = 0;
      endcase
      return 10'(g);
   endfunction : pd_gap

   function automatic logic [9:0] busy_gap(input logic [3:0] c);
      case (c)
         mem_timing_pkg::CMD_CAL_LONG:
            return 10'(mem_timing_pkg::CAL_LONG_NCK);
         mem_timing_pkg::CMD_CAL_SHORT:
            return 10'(mem_timing_pkg::CAL_SHORT_NCK);
         mem_timing_pkg::CMD_MRS:
            return 10'(mem_timing_pkg::MOD_NCK);
         default:
            return 10'h001;
      endcase
   endfunction : busy_gap

   always_comb
   begin
      next_state = state;
      case (state)
         ST_RUN:
            if (rise && enter_pd)
               next_state = ST_PD;
            else if (fire && req_cmd == mem_timing_pkg::CMD_LEVEL_ON)
               next_state = ST_LEVEL;
         ST_PD:
            if (rise && exit_pd)
               next_state = ST_RUN;
         ST_LEVEL:
            if (rise && !req_strobe
                && req_cmd == mem_timing_pkg::CMD_LEVEL_OFF && req_valid)
               next_state = ST_RUN;
         default:
            next_state = ST_RUN;
      endcase
   end

   // Link clock divider; the link rises on 'rise'
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         div  <= 5'h00;
         lclk <= 1'b0;
      end
      else if (div == 5'(mem_timing_pkg::LINK_HALF_DIV - 1))
      begin
         div  <= 5'h00;
         lclk <= !lclk;
      end
      else
         div <= div + 5'h01;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state       <= ST_RUN;
         cmd_wait    <= 10'(mem_timing_pkg::CAL_INIT_NCK);
         locked_wait <= 10'h000;
         pd_wait     <= 10'h000;
         pd_count    <= 10'h000;
         term_count  <= 10'h000;
         level_count <= 10'h000;
         cmd_out     <= 4'h0;
         chop_out    <= 1'b0;
      end
      else if (rise)
      begin
         state   <= next_state;
         cmd_out <= fire ? req_cmd : 4'(mem_timing_pkg::CMD_NOP);
         chop_out <= req_chop;
         pd_count <= (state == ST_PD) ? pd_count + 10'h001 : 10'h000;
         if (state == ST_PD && exit_pd)
         begin
            cmd_wait    <= 10'(EXIT_GAP);
            locked_wait <= req_frozen ? 10'(FROZEN_GAP) : 10'h000;
         end
         else if (fire)
         begin
            cmd_wait    <= busy_gap(req_cmd) - 10'h001;
            pd_wait     <= max10(pd_wait, pd_gap(req_cmd, req_chop));
            locked_wait <= (locked_wait != 10'h000)
                         ? locked_wait - 10'h001 : 10'h000;
         end
         else
         begin
            cmd_wait    <= (cmd_wait != 10'h000) ? cmd_wait - 10'h001 : 10'h000;
            locked_wait <= (locked_wait != 10'h000)
                         ? locked_wait - 10'h001 : 10'h000;
            pd_wait     <= (pd_wait != 10'h000) ? pd_wait - 10'h001 : 10'h000;
         end
         // Termination stays high for its full hold, even if dropped early;
         // it may change in power-down too, where the device follows it
         // without its clock
         if (req_term && !term_busy)
            term_count <= wr_long ? 10'(mem_timing_pkg::HOLD_LONG_NCK)
                        : 10'(mem_timing_pkg::HOLD_SHORT_NCK);
         else if (term_busy)
         begin
            if (wr_long)
               term_count <= 10'(mem_timing_pkg::HOLD_LONG_NCK);
            else if (drop_term)
               term_count <= term_count - 10'h001;
         end
         level_count <= (state == ST_LEVEL && level_count != 10'h3FF)
                      ? level_count + 10'h001 : 10'h000;
      end
   end

   // Three-stage sampler for the level answer; it counts once the last
   // two stages agree
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         level_sync   <= 3'h0;
         level_sample <= 1'b0;
      end
      else
      begin
         level_sync <= {level_sync[1:0], link.level_data};
         if (level_sync[2] == level_sync[1])
            level_sample <= level_sync[2];
      end
   end

   assign link.link_clk = lclk;
   assign link.clk_enable = (state != ST_PD);
   assign link.termination_control = term_busy;
   assign link.cmd = cmd_out;
   assign link.chop = chop_out;
   assign link.strobe_oe = (state == ST_LEVEL)
      && (level_count >= 10'(mem_timing_pkg::LEVEL_STROBE_EN));
   assign link.strobe_out = link.strobe_oe && req_strobe
      && (level_count >= 10'(mem_timing_pkg::LEVEL_FIRST_NCK));
endmodule : mem_ctrl_end
`default_nettype wire

/* design/mem_dev_end.sv */
// Device end: samples the link clock, honours commands and termination
`timescale 1ns/10ps
`default_nettype none
module mem_dev_end #(
   parameter int WRITE_LATENCY = 5
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // Status to the user side
   output logic      cmd_strobe,
   output logic [3:0] cmd_taken,
   output logic      write_start,
   output logic      power_down,
   output logic      cal_busy,
   // Link
   mem_link_if.mem   link
);
   logic [2:0] ck_s, ce_s, tc_s, st_s;
   logic [9:0] cal_count;
   logic [2:0] ce_low_count;
   logic       level_mode;
   logic       level_q;
   logic [7:0] wr_count;
   logic       wr_pending;
   logic [3:0] term_delay;
   logic       term_q;
   logic [3:0] lvl_delay;
   logic       cmd_path_on;

   // Second and third stages must both be high before a rise counts
   wire ck_hi   = (ck_s[2] & ck_s[1]);
   logic ck_hi_q;
   wire edge_up = ck_hi && !ck_hi_q;
   wire ce_hi   = ce_s[2] & ce_s[1];
   wire tc_hi   = tc_s[2] & tc_s[1];
   wire st_hi   = st_s[2] & st_s[1];
   wire [3:0] cmd_in = link.cmd;
   wire accept = edge_up && cmd_path_on && cal_count == 10'h000;
   wire is_write = (cmd_in == mem_timing_pkg::CMD_WR)
                || (cmd_in == mem_timing_pkg::CMD_WRA);
   wire [7:0] wr_delay = 8'(WRITE_LATENCY) + (link.chop
      ? 8'(mem_timing_pkg::CHOP4_EXTRA) : 8'(mem_timing_pkg::BURST8_EXTRA));

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         ck_s    <= 3'h0;
         ce_s    <= 3'h0;
         tc_s    <= 3'h0;
         st_s    <= 3'h0;
         ck_hi_q <= 1'b0;
      end
      else
      begin
         ck_s    <= {ck_s[1:0], link.link_clk};
         ce_s    <= {ce_s[1:0], link.clk_enable};
         tc_s    <= {tc_s[1:0], link.termination_control};
         st_s    <= {st_s[1:0], link.strobe_out & link.strobe_oe};
         ck_hi_q <= ck_hi;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         cal_count    <= 10'(mem_timing_pkg::CAL_INIT_NCK);
         ce_low_count <= 3'h0;
         cmd_path_on  <= 1'b1;
         level_mode   <= 1'b0;
         cmd_strobe   <= 1'b0;
         cmd_taken    <= 4'h0;
         wr_count     <= 8'h00;
         wr_pending   <= 1'b0;
         write_start  <= 1'b0;
         power_down   <= 1'b0;
      end
      else
      begin
         cmd_strobe  <= accept && cmd_in != mem_timing_pkg::CMD_NOP;
         write_start <= 1'b0;
         if (accept)
            cmd_taken <= cmd_in;
         if (edge_up)
         begin
            if (cal_count != 10'h000)
               cal_count <= cal_count - 10'h001;
            if (!ce_hi && ce_low_count != 3'(mem_timing_pkg::CMD_DISABLE_NCK))
               ce_low_count <= ce_low_count + 3'h1;
            else if (ce_hi)
               ce_low_count <= 3'h0;
            cmd_path_on <= ce_hi
               || ce_low_count + 3'h1 < 3'(mem_timing_pkg::CMD_DISABLE_NCK);
            // Pending work finishes before power-down is reported
            power_down <= !ce_hi && !wr_pending && cal_count == 10'h000;
            if (wr_pending)
            begin
               if (wr_count == 8'h01)
               begin
                  wr_pending  <= 1'b0;
                  write_start <= 1'b1;
               end
               wr_count <= wr_count - 8'h01;
            end
         end
         if (accept)
         begin
            if (is_write && !wr_pending)
            begin
               wr_pending <= 1'b1;
               wr_count   <= wr_delay;
            end
            case (cmd_in)
               // The command's own clock is the first of the period
               mem_timing_pkg::CMD_CAL_LONG:
                  cal_count <= 10'(mem_timing_pkg::CAL_LONG_NCK - 1);
               mem_timing_pkg::CMD_CAL_SHORT:
                  cal_count <= 10'(mem_timing_pkg::CAL_SHORT_NCK - 1);
               mem_timing_pkg::CMD_LEVEL_ON:
                  level_mode <= 1'b1;
               mem_timing_pkg::CMD_LEVEL_OFF:
                  level_mode <= 1'b0;
               default:
                  level_mode <= level_mode;
            endcase
         end
      end
   end

   // Termination follows its control after a fixed delay on clk
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         term_delay <= 4'h0;
         term_q     <= 1'b0;
         lvl_delay  <= 4'h0;
         level_q    <= 1'b0;
      end
      else
      begin
         if (tc_hi != term_q)
         begin
            term_delay <= term_delay + 4'h1;
            if (term_delay + 4'h1 >= 4'(mem_timing_pkg::ASYNC_TERM_CYC))
            begin
               term_q     <= tc_hi;
               term_delay <= 4'h0;
            end
         end
         else
            term_delay <= 4'h0;
         if (level_mode && st_hi && lvl_delay == 4'h0)
         begin
            level_q   <= ck_hi;
            lvl_delay <= 4'(mem_timing_pkg::LEVEL_OUT_CYC);
         end
         else if (lvl_delay != 4'h0 && !st_hi)
            lvl_delay <= lvl_delay - 4'h1;
      end
   end

   assign cal_busy = (cal_count != 10'h000);
   assign link.termination_on = term_q;
   assign link.level_data = level_q;
   assign link.level_data_oe = level_mode;
endmodule : mem_dev_end
`default_nettype wire

/* design/mem_link_if.sv */
// Interface joining the memory controller end and the memory device end
`timescale 1ns/10ps
`default_nettype none
interface mem_link_if;
   logic       link_clk;
   logic       clk_enable;
   logic       termination_control;
   logic [3:0] cmd;
   logic       chop;
   logic       strobe_out;
   logic       strobe_oe;
   logic       level_data;
   logic       level_data_oe;
   logic       termination_on;
   modport ctrl (output link_clk, output clk_enable,
                 output termination_control, output cmd, output chop,
                 output strobe_out, output strobe_oe,
                 input level_data, input level_data_oe);
   modport mem  (input link_clk, input clk_enable,
                 input termination_control, input cmd, input chop,
                 input strobe_out, input strobe_oe,
                 output level_data, output level_data_oe,
                 output termination_on);
endinterface : mem_link_if
`default_nettype wire

/* design/mem_timing_pkg.sv */
// Shared constants for the power-down, termination and calibration timing link
package mem_timing_pkg;
   localparam int CLK_PERIOD_PS    = 8000;
   // Link clock is divided from clk by 2*LINK_HALF_DIV
   localparam int LINK_HALF_DIV    = 10;
   localparam int PD_MIN_LINK      = 3;
   localparam int EXIT_NS          = 6;
   localparam int EXIT_NCK         = 3;
   localparam int FROZEN_EXIT_NS   = 24;
   localparam int FROZEN_EXIT_NCK  = 10;
   localparam int CMD_DISABLE_NCK  = 2;
   localparam int ACT_PDEN_NCK     = 2;
   localparam int RD_PDEN_EXTRA    = 5;
   localparam int BURST8_EXTRA     = 4;
   localparam int CHOP4_EXTRA      = 2;
   localparam int MOD_NCK          = 12;
   localparam int HOLD_SHORT_NCK   = 4;
   localparam int HOLD_LONG_NCK    = 6;
   localparam int CAL_INIT_NCK     = 512;
   localparam int CAL_LONG_NCK     = 256;
   localparam int CAL_SHORT_NCK    = 64;
   localparam int LEVEL_STROBE_EN  = 25;
   localparam int LEVEL_FIRST_NCK  = 40;
   localparam int ASYNC_TERM_MIN_PS = 2000;
   localparam int ASYNC_TERM_MAX_PS = 8500;
   localparam int LEVEL_OUT_MAX_PS  = 7500;
   // Async termination delay in clk cycles: the least figure, rounded up
   localparam int ASYNC_TERM_CYC =
      (ASYNC_TERM_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int LEVEL_OUT_CYC =
      (LEVEL_OUT_MAX_PS / CLK_PERIOD_PS) < 1 ? 1
      : LEVEL_OUT_MAX_PS / CLK_PERIOD_PS;
   typedef enum logic [3:0] {
      CMD_NOP, CMD_ACT, CMD_PRE, CMD_REF, CMD_RD, CMD_RDA, CMD_WR,
      CMD_WRA, CMD_MRS, CMD_CAL_LONG, CMD_CAL_SHORT, CMD_LEVEL_ON,
      CMD_LEVEL_OFF
   } cmd_type;
   // Larger of a nanosecond figure (rounded up) and a clock count
   function automatic int ns_or_nck(input int ns, input int nck,
                                    input int tck_ps);
      int c;
      c = (ns * 1000 + tck_ps - 1) / tck_ps;
      return (c > nck) ? c : nck;
   endfunction : ns_or_nck
endpackage : mem_timing_pkg

/* verif/mem_link_checker.sv */
// Checker on the link between the controller end and the device end
`timescale 1ns/10ps
`default_nettype none
module mem_link_checker #(
   parameter int READ_LATENCY = 5
) (
   // Clock and reset
   input wire logic       clk,
   input wire logic       resetn,
   // Link
   input wire logic       link_clk,
   input wire logic       clk_enable,
   input wire logic       termination_control,
   input wire logic [3:0] cmd,
   input wire logic       strobe_out,
   input wire logic       strobe_oe
);
   logic       prev_lc;
   logic       prev_cke;
   logic [3:0] prev_cmd;
   logic [3:0] last_cmd;
   logic [9:0] rises;
   logic [9:0] gap;
   logic [9:0] exit_gap;
   logic [9:0] lvl_gap;
   logic [6:0] cke_lo;
   logic [7:0] term_hi;
   wire link_rise = link_clk & ~prev_lc;
   wire new_cmd = (cmd != mem_timing_pkg::CMD_NOP) && (cmd != prev_cmd);
   wire lvl_on = new_cmd && (cmd == mem_timing_pkg::CMD_LEVEL_ON);
   // Link clocks from one command edge to the next, the closing edge counted and the opening one not
   wire [10:0] gap_span = {1'b0, gap} + 11'h001;
   wire [10:0] lvl_span = {1'b0, lvl_gap} + 11'h001;
   // Counters saturate so that long idle spells never wrap into a false gap
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         {prev_lc, prev_cke, prev_cmd, last_cmd} <= '0;
         {rises, gap, exit_gap, lvl_gap, cke_lo, term_hi} <= '0;
      end
      else
      begin
         prev_lc  <= link_clk;
         prev_cke <= clk_enable;
         prev_cmd <= cmd;
         last_cmd <= new_cmd ? cmd : last_cmd;
         rises    <= rises + 10'(link_rise && rises != 10'h3FF);
         gap      <= new_cmd ? 10'h0 : gap + 10'(link_rise && gap != 10'h3FF);
         exit_gap <= (clk_enable & ~prev_cke) ? 10'h0
                     : exit_gap + 10'(link_rise && exit_gap != 10'h3FF);
         lvl_gap  <= lvl_on ? 10'h0
                     : lvl_gap + 10'(link_rise && lvl_gap != 10'h3FF);
         cke_lo   <= clk_enable ? 7'h0 : cke_lo + 7'(cke_lo != 7'h7F);
         term_hi  <= !termination_control ? 8'h0
                     : term_hi + 8'(term_hi != 8'hFF);
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   link_half_period_a: assert property (
      $changed(link_clk) |=> $stable(link_clk)[*8])
      else $error("link clock half period too short");
   cmd_stands_a: assert property (new_cmd |=> $stable(cmd)[*8])
      else $error("command left the link too early");
   cal_init_gap_a: assert property (new_cmd |-> rises >= 10'd512)
      else $error("command during power-up calibration");
   cal_long_gap_a: assert property (
      new_cmd && last_cmd == mem_timing_pkg::CMD_CAL_LONG
      |-> gap_span >= 11'd256)
      else $error("command during full calibration");
   cal_short_gap_a: assert property (
      new_cmd && last_cmd == mem_timing_pkg::CMD_CAL_SHORT
      |-> gap_span >= 11'd64)
      else $error("command during short calibration");
   exit_gap_a: assert property (new_cmd |-> exit_gap >= 10'd3)
      else $error("command too soon after power-down exit");
   pd_min_width_a: assert property ($rose(clk_enable) |-> cke_lo >= 7'd60)
      else $error("power-down shorter than minimum");
   read_pd_gap_a: assert property (
      $fell(clk_enable) && (last_cmd == mem_timing_pkg::CMD_RD
      || last_cmd == mem_timing_pkg::CMD_RDA)
      |-> gap_span >= 11'(READ_LATENCY + mem_timing_pkg::RD_PDEN_EXTRA))
      else $error("power-down too soon after read");
   mode_pd_gap_a: assert property (
      $fell(clk_enable) && last_cmd == mem_timing_pkg::CMD_MRS
      |-> gap_span >= 11'(mem_timing_pkg::MOD_NCK))
      else $error("power-down too soon after mode set");
   term_hold_a: assert property ($fell(termination_control) |-> term_hi >= 8'd80)
      else $error("termination control released too early");
   strobe_enable_a: assert property (
      $rose(strobe_oe) |-> lvl_span >= 11'd25)
      else $error("levelling strobe driven too early");
   first_strobe_a: assert property (
      $rose(strobe_out) |-> lvl_span >= 11'd40)
      else $error("first levelling strobe pulse too early");
endmodule : mem_link_checker
`default_nettype wire

/* verif/tb.sv */
// Testbench joining both link ends and checking commands and timing
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic       clk, resetn, req_valid, req_chop, req_power_down, req_frozen;
   logic       req_term, req_strobe, req_ready, level_sample;
   logic       cmd_strobe, write_start, power_down, cal_busy, prev_lc;
   logic [3:0] req_cmd, cmd_taken;
   int         err_count, n_compared, cycles, rises, w, i;
   mem_link_if link_bus();
   mem_ctrl_end mem_ctrl_end_inst (.clk(clk), .resetn(resetn),
      .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
      .req_chop(req_chop), .req_power_down(req_power_down),
      .req_frozen(req_frozen), .req_term(req_term),
      .req_strobe(req_strobe), .level_sample(level_sample),
      .link(link_bus));
   mem_dev_end mem_dev_end_inst (.clk(clk), .resetn(resetn),
      .cmd_strobe(cmd_strobe), .cmd_taken(cmd_taken),
      .write_start(write_start), .power_down(power_down),
      .cal_busy(cal_busy), .link(link_bus));
   mem_link_checker mem_link_checker_inst (.clk(clk), .resetn(resetn),
      .link_clk(link_bus.link_clk), .clk_enable(link_bus.clk_enable),
      .termination_control(link_bus.termination_control),
      .cmd(link_bus.cmd), .strobe_out(link_bus.strobe_out),
      .strobe_oe(link_bus.strobe_oe));
   initial begin clk = 1'b0; forever #4 clk = ~clk; end
   always @(posedge clk)
   begin
      cycles++;
      prev_lc <= link_bus.link_clk;
      if (link_bus.link_clk === 1'b1 && prev_lc === 1'b0) rises++;
      if (cycles == 40000)
      begin
         err_count++;
         $display("ERROR %0t run timed out", $time);
         results();
      end
   end
   task automatic results();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results
   task automatic cmp_val(input logic [3:0] got, input logic [3:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %0t value %h expected %h", $time, got, exp);
      end
   endtask : cmp_val
   task automatic cmp_rng(input int got, input int lo, input int hi);
      n_compared++;
      if (got < lo || got > hi)
      begin
         err_count++;
         $display("ERROR %0t count %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask : cmp_rng
   // Waits up to n falling edges for a flag; returns edges waited
   task automatic wait_hi(ref logic f, input int n, output int k);
      k = 0;
      while (f !== 1'b1 && k < n) begin @(negedge clk); k++; end
   endtask : wait_hi
   task automatic issue(input logic [3:0] c, input logic ch, output int wr);
      int r0, k;
      r0 = rises;
      @(negedge clk);
      req_cmd = c; req_chop = ch; req_valid = 1'b1;
      wait_hi(req_ready, 12000, k);
      wr = rises - r0;
      @(negedge clk);
      req_valid = 1'b0;
      wait_hi(cmd_strobe, 60, k);
      cmp_val(cmd_taken, c);
   endtask : issue
   task automatic scn_init();
      cmp_val({3'h0, cal_busy}, 4'h1);
      issue(mem_timing_pkg::CMD_ACT, 1'b0, w);
      cmp_rng(w, 508, 514);
   endtask : scn_init
   task automatic scn_cmds();
      int lo;
      lo = 0;
      for (i = 2; i <= 11; i++)
      begin
         // The last pass sends an activate behind the short calibration
         issue(4'((i == 11) ? 1 : i), 1'b0, w);
         cmp_rng(w, lo, 2000);
         lo = (i == 9) ? 255 : (i == 10) ? 63 : 0;
      end
   endtask : scn_cmds
   task automatic scn_write(input logic ch);
      int r0, k;
      issue(mem_timing_pkg::CMD_WR, ch, w);
      r0 = rises;
      wait_hi(write_start, 400, k);
      cmp_rng(rises - r0, 5 + (ch ? 2 : 4), 5 + (ch ? 2 : 4));
   endtask : scn_write
   task automatic scn_pd(input logic frz);
      int k;
      issue(frz ? mem_timing_pkg::CMD_MRS : mem_timing_pkg::CMD_RD, 1'b0, w);
      req_power_down = 1'b1; req_frozen = frz;
      wait_hi(power_down, 600, k);
      cmp_val({3'h0, power_down}, 4'h1);
      req_cmd = mem_timing_pkg::CMD_ACT; req_valid = 1'b1; k = 0;
      repeat (100) begin @(negedge clk); k += int'(req_ready === 1'b1); end
      req_valid = 1'b0;
      cmp_rng(k, 0, 0);
      req_term = 1'b1;
      wait_hi(link_bus.termination_control, 100, k);
      @(negedge clk);
      req_term = 1'b0;
      wait_hi(link_bus.termination_on, 20, k);
      cmp_rng(k, 0, 4);
      @(negedge clk);
      req_power_down = 1'b0;
      wait_hi(link_bus.clk_enable, 600, k);
      issue(frz ? mem_timing_pkg::CMD_RD : mem_timing_pkg::CMD_ACT, 1'b0, w);
      cmp_rng(w, frz ? 10 : 3, 400);
   endtask : scn_pd
   task automatic scn_level();
      int r0, k;
      issue(mem_timing_pkg::CMD_LEVEL_ON, 1'b0, w);
      r0 = rises;
      req_strobe = 1'b1;
      wait_hi(link_bus.strobe_out, 2000, k);
      cmp_rng(rises - r0, 39, 60);
      wait_hi(link_bus.level_data_oe, 60, k);
      cmp_val({3'h0, link_bus.level_data_oe}, 4'h1);
      // The strobe rises with the link clock, so the level seen is high
      wait_hi(level_sample, 12, k);
      cmp_val({3'h0, level_sample}, 4'h1);
      req_strobe = 1'b0;
      issue(mem_timing_pkg::CMD_LEVEL_OFF, 1'b0, w);
   endtask : scn_level
   initial
   begin
      {resetn, req_valid, req_chop, req_power_down, req_frozen} = '0;
      {req_term, req_strobe, prev_lc} = '0;
      req_cmd = mem_timing_pkg::CMD_NOP;
      {err_count, n_compared, cycles, rises} = '0;
      repeat (8) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      scn_init();
      scn_cmds();
      scn_write(1'b0);
      scn_write(1'b1);
      scn_pd(1'b0);
      scn_pd(1'b1);
      scn_level();
      results();
   end
endmodule : tb
`default_nettype wire
